// *** core/lcp_pkg.sv ***
package lcp_pkg;
  localparam int unsigned DATA_W      = 16;
  localparam logic        STYLE_8080  = 1'b0;
  localparam logic        STYLE_6800  = 1'b1;
  localparam logic        SEL_LOW     = 1'b0;
  localparam logic        SEL_HIGH    = 1'b1;
  localparam logic [1:0]  ACC_NONE    = 2'h0;
  localparam logic [1:0]  ACC_READ    = 2'h1;
  localparam logic [1:0]  ACC_WRITE   = 2'h2;
  typedef enum logic [2:0] {
    LCP_OP_NONE,
    LCP_OP_STATUS_RD,
    LCP_OP_DATA_RD,
    LCP_OP_PARAM_WR,
    LCP_OP_CMD_WR
  } lcp_op_t;
endpackage

// *** core/lcp_strobe_if.sv ***
`timescale 1ns/1ps
interface lcp_strobe_if;
  logic [1:0] access;
  logic       sel;
  logic       cs_active;
  modport dec (output access, output sel, output cs_active);
  modport top (input access, input sel, input cs_active);
endinterface

// *** core/lcp_pin_decode.sv ***
`timescale 1ns/1ps
module lcp_pin_decode (
  input  wire logic    bus_style_select_in,
  input  wire logic    cs_n_in,
  input  wire logic    rd_en_in,
  input  wire logic    wr_rw_in,
  input  wire logic    command_data_select_in,
  lcp_strobe_if.dec    st
);
  always_comb begin
    st.cs_active = !cs_n_in;
    st.sel       = command_data_select_in;
    st.access    = lcp_pkg::ACC_NONE;
    if (st.cs_active) begin                                   // [RQ10]
      if (bus_style_select_in == lcp_pkg::STYLE_8080) begin   // [RQ2]
        if (!rd_en_in) begin                                  // [RQ3]
          st.access = lcp_pkg::ACC_READ;
        end else if (!wr_rw_in) begin
          st.access = lcp_pkg::ACC_WRITE;
        end
      end else if (rd_en_in) begin                            // [RQ4] [RQ5]
        st.access = wr_rw_in ? lcp_pkg::ACC_READ : lcp_pkg::ACC_WRITE;
      end
    end
  end
endmodule // lcp_pin_decode

// *** core/lcp_bus_port.sv ***
// Overview of operation
// RQ1: Bidirectional 16-bit bus, driven only on reads.
// RQ2: Static select pin picks 8080 or 6800 style.
// RQ3: 8080 style drives bus only during read strobe.
// RQ4: 6800 style treats read pin as enable.
// RQ5: 6800 transfers happen while enable is high.
// RQ6: Host pulses read strobe low per read.
// RQ7: 8080 write data captured at strobe rise.
// RQ8: 6800 read/write high reads, low writes.
// RQ9: Select line decodes status, data, parameter, command.
// RQ10: Deselected chip ignores strobes, bus released.
`timescale 1ns/1ps
module lcp_bus_port (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        bus_style_select_in,
  input  wire logic                        bus_style_select_aux_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        rd_en_in,
  input  wire logic                        wr_rw_in,
  input  wire logic                        command_data_select_in,
  input  wire logic [lcp_pkg::DATA_W-1:0]  data_in,
  output logic      [lcp_pkg::DATA_W-1:0]  data_out,
  output logic                             data_oe_out,
  input  wire logic [lcp_pkg::DATA_W-1:0]  status_in,
  input  wire logic [lcp_pkg::DATA_W-1:0]  rd_data_in,
  output logic                             cmd_wr_out,
  output logic                             param_wr_out,
  output logic                             status_rd_out,
  output logic                             data_rd_out,
  output logic      [lcp_pkg::DATA_W-1:0]  wr_data_out
);
  lcp_strobe_if st ();

  lcp_pin_decode u_dec (
    .bus_style_select_in    (bus_style_select_in),
    .cs_n_in                (cs_n_in),
    .rd_en_in               (rd_en_in),
    .wr_rw_in               (wr_rw_in),
    .command_data_select_in (command_data_select_in),
    .st                     (st)
  );

  function automatic lcp_pkg::lcp_op_t op_of(input logic [1:0] acc, input logic sel);
    lcp_pkg::lcp_op_t r;
    r = lcp_pkg::LCP_OP_NONE;
    if (acc == lcp_pkg::ACC_READ) begin
      r = (sel == lcp_pkg::SEL_LOW) ? lcp_pkg::LCP_OP_STATUS_RD : lcp_pkg::LCP_OP_DATA_RD;
    end else if (acc == lcp_pkg::ACC_WRITE) begin
      r = (sel == lcp_pkg::SEL_LOW) ? lcp_pkg::LCP_OP_PARAM_WR : lcp_pkg::LCP_OP_CMD_WR;
    end
    return r;
  endfunction

  lcp_pkg::lcp_op_t             op_q, op_d;
  logic [lcp_pkg::DATA_W-1:0]   wdat_q, wdat_d;
  logic [lcp_pkg::DATA_W-1:0]   dout_q, dout_d;
  logic [lcp_pkg::DATA_W-1:0]   wout_q, wout_d;
  logic                         oe_q, oe_d;
  logic                         cmd_q, cmd_d, par_q, par_d, srd_q, srd_d, drd_q, drd_d;
  lcp_pkg::lcp_op_t             cur;
  logic                         ended;

  always_comb begin
    cur    = op_of(st.access, st.sel);                                  // [RQ9] [RQ8] [RQ10]
    ended  = (op_q != lcp_pkg::LCP_OP_NONE) && (cur != op_q);
    op_d   = cur;
    wdat_d = (st.access == lcp_pkg::ACC_WRITE) ? data_in : wdat_q;      // [RQ5]
    srd_d  = (cur == lcp_pkg::LCP_OP_STATUS_RD) && (op_q != cur);
    drd_d  = (cur == lcp_pkg::LCP_OP_DATA_RD) && (op_q != cur);
    cmd_d  = ended && (op_q == lcp_pkg::LCP_OP_CMD_WR);                 // [RQ7] [RQ5]
    par_d  = ended && (op_q == lcp_pkg::LCP_OP_PARAM_WR);               // [RQ7] [RQ5]
    wout_d = (cmd_d || par_d) ? wdat_q : wout_q;                        // [RQ7]
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_q   <= lcp_pkg::LCP_OP_NONE;
      wdat_q <= '0;
      wout_q <= '0;
      cmd_q  <= 1'b0;
      par_q  <= 1'b0;
      srd_q  <= 1'b0;
      drd_q  <= 1'b0;
    end else begin
      op_q   <= op_d;
      wdat_q <= wdat_d;
      wout_q <= wout_d;
      cmd_q  <= cmd_d;
      par_q  <= par_d;
      srd_q  <= srd_d;
      drd_q  <= drd_d;
    end
  end

  always_comb begin
    oe_d   = (st.access == lcp_pkg::ACC_READ);                          // [RQ1] [RQ3] [RQ4] [RQ10]
    dout_d = dout_q;
    if (cur == lcp_pkg::LCP_OP_STATUS_RD) begin
      dout_d = status_in;
    end else if (cur == lcp_pkg::LCP_OP_DATA_RD) begin
      dout_d = rd_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dout_q <= '0;
      oe_q   <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_q   <= oe_d;
    end
  end

  assign data_out      = dout_q;
  assign data_oe_out   = oe_q;
  assign cmd_wr_out    = cmd_q;
  assign param_wr_out  = par_q;
  assign status_rd_out = srd_q;
  assign data_rd_out   = drd_q;
  assign wr_data_out   = wout_q;

  a_oe_follows_rd: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ3]
    (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_8080 && !rd_en_in) |=> data_oe_out)
    else $error("Bus not driven during read strobe.");

  a_oe_off_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ1] [RQ10]
    (cs_n_in || (bus_style_select_in == lcp_pkg::STYLE_8080 && rd_en_in)) |=> !data_oe_out)
    else $error("Bus driven outside a read.");

  a_en_not_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ4]
    (bus_style_select_in == lcp_pkg::STYLE_6800 && !rd_en_in) |=> !data_oe_out)
    else $error("Enable low treated as read strobe.");

  a_rw_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ8] [RQ5]
    (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_6800 && rd_en_in && wr_rw_in) |=> data_oe_out)
    else $error("6800 read not driven while enable high.");

  sequence s_cmd_write;
    (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_8080 && rd_en_in && !wr_rw_in && command_data_select_in)
    ##1 (cs_n_in || wr_rw_in);
  endsequence

  a_cmd_on_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ7] [RQ9]
    s_cmd_write |=> (cmd_wr_out && !param_wr_out))
    else $error("Command write not issued at strobe rise.");

  a_wr_data: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ7]
    s_cmd_write |=> (wr_data_out == $past(data_in, 2)))
    else $error("Write data not the captured bus value.");

  a_status_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9]
    status_rd_out |-> $past(!command_data_select_in && !cs_n_in))
    else $error("Status read without select low.");

  a_no_cs_strobe: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ10]
    $past(cs_n_in) && $past(cs_n_in, 2) |-> !(status_rd_out || data_rd_out || cmd_wr_out || param_wr_out))
    else $error("Strobe output while deselected.");

  sequence s_par_write;
    (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_8080 && rd_en_in && !wr_rw_in && !command_data_select_in)
    ##1 (cs_n_in || wr_rw_in);
  endsequence

  a_par_on_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ7] [RQ9]
    s_par_write |=> (param_wr_out && !cmd_wr_out))
    else $error("Parameter write not issued at strobe rise.");

  a_par_data: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ7]
    s_par_write |=> (wr_data_out == $past(data_in, 2)))
    else $error("Parameter data not the captured bus value.");

  sequence s_e_write;
    (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_6800 && rd_en_in && !wr_rw_in)
    ##1 (cs_n_in || !rd_en_in);
  endsequence

  a_e_wr_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ5] [RQ8] [RQ9]
    s_e_write |=> ((cmd_wr_out == $past(command_data_select_in, 2)) &&
                   (param_wr_out != $past(command_data_select_in, 2))))
    else $error("Enable write pulse does not match select.");

  a_e_wr_data: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ5]
    s_e_write |=> (wr_data_out == $past(data_in, 2)))
    else $error("Enable write data not the bus value.");

  a_e_wr_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ8] [RQ1]
    (bus_style_select_in == lcp_pkg::STYLE_6800 && rd_en_in && !wr_rw_in) |=> !data_oe_out)
    else $error("Bus driven during an enable write.");

  a_e_dout: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ5] [RQ8] [RQ9]
    (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_6800 && rd_en_in && wr_rw_in)
    |=> (data_out == $past(command_data_select_in ? rd_data_in : status_in)))
    else $error("Enable read returned the wrong word.");

  a_rd_dout_status: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9] [RQ3]
    (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_8080 && !rd_en_in && !command_data_select_in)
    |=> (data_out == $past(status_in)))
    else $error("Status word not driven on read.");

  a_rd_dout_data: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9] [RQ3]
    (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_8080 && !rd_en_in && command_data_select_in)
    |=> (data_out == $past(rd_data_in)))
    else $error("Data word not driven on read.");

  sequence s_status_start;
    (bus_style_select_in == lcp_pkg::STYLE_8080 && (cs_n_in || rd_en_in))
    ##1 (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_8080 && !rd_en_in && !command_data_select_in);
  endsequence

  a_status_start: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9] [RQ3]
    s_status_start |=> status_rd_out)
    else $error("Status read pulse missing at strobe fall.");

  sequence s_data_start;
    (bus_style_select_in == lcp_pkg::STYLE_8080 && (cs_n_in || rd_en_in))
    ##1 (!cs_n_in && bus_style_select_in == lcp_pkg::STYLE_8080 && !rd_en_in && command_data_select_in);
  endsequence

  a_data_start: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9] [RQ3]
    s_data_start |=> data_rd_out)
    else $error("Data read pulse missing at strobe fall.");

  a_data_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9]
    data_rd_out |-> $past(command_data_select_in && !cs_n_in))
    else $error("Data read without select high.");

  a_cmd_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9] [RQ10]
    cmd_wr_out |-> $past(!cs_n_in && command_data_select_in, 2))
    else $error("Command write without select high.");

  a_par_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9] [RQ10]
    param_wr_out |-> $past(!cs_n_in && !command_data_select_in, 2))
    else $error("Parameter write without select low.");

  a_wr_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ7]
    $changed(wr_data_out) |-> (cmd_wr_out || param_wr_out))
    else $error("Write data changed without a write pulse.");
endmodule // lcp_bus_port

// *** verif/lcp_host_model.sv ***
`timescale 1ns/1ps
module lcp_host_model (
  input  wire logic        clk_in,
  input  wire logic        style_in,
  input  wire logic [15:0] bus_in,
  output logic             cs_n_out,
  output logic             rd_en_out,
  output logic             wr_rw_out,
  output logic             sel_out,
  output logic [15:0]      d_out
);
  initial begin
    cs_n_out = 1'b1;
    rd_en_out = 1'b1;
    wr_rw_out = 1'b1;
    sel_out = 1'b0;
    d_out = 16'h0000;
  end
  // Released data lines show the inverse of the last value.
  task automatic xfer(input logic rd, input logic s, input logic [15:0] d, input logic cs,
                      output logic [15:0] q);
    @(posedge clk_in);
    #1;
    cs_n_out = ~cs;
    sel_out = s;
    d_out = rd ? ~d_out : d;
    rd_en_out = ~style_in;
    wr_rw_out = ~style_in | rd;
    @(posedge clk_in);
    #1;
    rd_en_out = style_in | ~rd;
    wr_rw_out = rd;
    repeat (3) @(posedge clk_in);
    q = bus_in;
    #1;
    rd_en_out = ~style_in;
    wr_rw_out = 1'b1;
    @(posedge clk_in);
    #1;
    cs_n_out = 1'b1;
    d_out = ~d_out;
  endtask
endmodule // lcp_host_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic        clk_in, rst_n_in, bus_style_select_in, cs_n_in, rd_en_in, wr_rw_in;
  logic        command_data_select_in, data_oe_out, cmd_wr_out, param_wr_out;
  logic        status_rd_out, data_rd_out, rd, s, cs;
  logic [15:0] data_in, data_out, status_in, rd_data_in, wr_data_out, hd, d, q;
  logic [7:0]  n_c, n_p, n_s, n_d, e_c, e_p, e_s, e_d;
  int          err_count, tests_run;
  logic [36:0] all_outs;
  assign all_outs = {data_oe_out, cmd_wr_out, param_wr_out, status_rd_out, data_rd_out, wr_data_out, data_out};
  assign data_in = data_oe_out ? data_out : hd;
  lcp_bus_port dut_u (.clk_in, .rst_n_in, .bus_style_select_in, .bus_style_select_aux_in(1'b0),
    .cs_n_in, .rd_en_in, .wr_rw_in, .command_data_select_in, .data_in, .data_out, .data_oe_out,
    .status_in, .rd_data_in, .cmd_wr_out, .param_wr_out, .status_rd_out, .data_rd_out, .wr_data_out);
  lcp_host_model host_u (.clk_in, .style_in(bus_style_select_in), .bus_in(data_in),
    .cs_n_out(cs_n_in), .rd_en_out(rd_en_in), .wr_rw_out(wr_rw_in),
    .sel_out(command_data_select_in), .d_out(hd));
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      {n_c, n_p, n_s, n_d} <= '0;
    end else begin
      n_c <= n_c + 8'(cmd_wr_out);
      n_p <= n_p + 8'(param_wr_out);
      n_s <= n_s + 8'(status_rd_out);
      n_d <= n_d + 8'(data_rd_out);
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
  initial begin
    {e_c, e_p, e_s, e_d} = '0;
    {rst_n_in, bus_style_select_in, status_in, rd_data_in} = '0;
    void'($urandom(49));
    repeat (20) @(posedge clk_in);
    #1;
    `CHK(all_outs, 37'h0)
    rst_n_in = 1'b1;
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        rst_n_in = 1'b0;
        {e_c, e_p, e_s, e_d} = '0;
        @(posedge clk_in);
        #1;
        `CHK(all_outs, 37'h0)
        rst_n_in = 1'b1;
      end
      bus_style_select_in = (i >= 20);
      {rd, s} = (i % 20 < 4) ? 2'(i) : 2'($urandom);
      cs = (i % 5 != 3);
      d = 16'($urandom);
      status_in = 16'($urandom);
      rd_data_in = 16'($urandom);
      host_u.xfer(rd, s, d, cs, q);
      repeat (3) @(posedge clk_in);
      #1;
      if (cs) begin
        e_c += 8'(!rd && s);
        e_p += 8'(!rd && !s);
        e_s += 8'(rd && !s);
        e_d += 8'(rd && s);
      end
      if (rd) `CHK(q, cs ? (s ? rd_data_in : status_in) : ~hd)
      if (cs && !rd) `CHK(wr_data_out, d)
      `CHK(data_oe_out, 1'b0)
      `CHK({n_c, n_p, n_s, n_d}, {e_c, e_p, e_s, e_d})
    end
    wrap_up();
  end
endmodule // tb_top
